/* File: ufsc_pkg.sv */
// Package with register map, field layout and reset values of the FIFO shadow controls.
package ufsc_pkg;

  // Documented shadow registers, byte addresses on the register port.
  localparam logic [31:0] UFSC_SH_DMA_MODE_ADDR = 32'h5000_1094;
  localparam logic [31:0] UFSC_SH_FIFO_EN_ADDR = 32'h5000_1098;
  localparam logic [31:0] UFSC_SH_RX_TRIG_ADDR = 32'h5000_109c;

  // Full control word, character data and status.
  localparam logic [31:0] UFSC_FCW_ADDR = 32'h5000_10c0;
  localparam logic [31:0] UFSC_DATA_ADDR = 32'h5000_10c4;
  localparam logic [31:0] UFSC_STATUS_ADDR = 32'h5000_10c8;

  // Field positions inside the fifo_control_word.
  localparam int UFSC_FCW_EN_BIT = 0;
  localparam int UFSC_FCW_RX_RST_BIT = 1;
  localparam int UFSC_FCW_TX_RST_BIT = 2;
  localparam int UFSC_FCW_DMA_BIT = 3;
  localparam int UFSC_FCW_TRIG_LSB = 6;
  localparam int UFSC_FCW_TRIG_MSB = 7;

  // Field positions inside the shadow registers.
  localparam int UFSC_SH_BIT = 0;
  localparam int UFSC_SH_TRIG_LSB = 0;
  localparam int UFSC_SH_TRIG_MSB = 1;

  // Field positions inside the status register.
  localparam int UFSC_ST_RX_NEMPTY_BIT = 0;
  localparam int UFSC_ST_TX_FULL_BIT = 1;
  localparam int UFSC_ST_RX_HIT_BIT = 2;
  localparam int UFSC_ST_FIFO_EN_BIT = 3;
  localparam int UFSC_ST_RX_CNT_LSB = 8;
  localparam int UFSC_ST_TX_CNT_LSB = 16;

  // Receive trigger codes.
  localparam logic [1:0] UFSC_TRIG_ONE = 2'h0;
  localparam logic [1:0] UFSC_TRIG_QUARTER = 2'h1;
  localparam logic [1:0] UFSC_TRIG_HALF = 2'h2;
  localparam logic [1:0] UFSC_TRIG_TWO_SHORT = 2'h3;

  // Reset values.
  localparam logic UFSC_RST_DMA_MODE = 1'h0;
  localparam logic UFSC_RST_FIFO_EN = 1'h0;
  localparam logic [1:0] UFSC_RST_RX_TRIG = 2'h0;

  // Data path sizes.
  localparam int UFSC_CHAR_W = 8;
  localparam int UFSC_FIFO_DEPTH = 16;

endpackage

/* File: ufsc_fifo.sv */
// Flip-flop FIFO with flush and a one-entry capacity mode.
module ufsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic cap_one,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic full_ff;
  logic [CW-1:0] nxt_count;
  logic [CW-1:0] cap;
  logic push;
  logic pop;

  assign push = in_valid & ~full_ff & ~flush;
  assign pop = (count_ff != '0) & out_ready & ~flush;
  assign cap = cap_one ? CW'(1) : CW'(DEPTH);
  assign in_ready = ~full_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign count = count_ff;

  always_comb begin
    nxt_count = count_ff;
    if (flush) begin
      nxt_count = '0;
    end else if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= '0;
      full_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      full_ff <= (nxt_count >= cap);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + AW'(1);
      end
    end
  end

  // Storage is not cleared on flush; only the pointers matter.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

/* File: ufsc_top.sv */
// Serial port FIFO control word with its shadow registers, FIFOs and DMA requests.
//
// Overview of operation
// - Shadow DMA-mode bit 0 drives control word bit 3.
// - A shadow write changes only its own control word field.
// - DMA mode 0 or 1 selects the signalling scheme of both DMA requests.
// - Shadow FIFO-enable bit 0 drives control word bit 0, both FIFOs.
// - Clearing FIFO enable after it was set resets both FIFO controllers.
// - Shadow trigger bits 1:0 drive control word bits 7:6, receive interrupt level.
// - In DMA mode 1 the trigger level also raises the receive DMA request.
// - Trigger code 00 means one character, code 11 means two short of full.
module ufsc_top
  import ufsc_pkg::*;
#(
  parameter int CHAR_W = UFSC_CHAR_W,
  parameter int DEPTH = UFSC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [CHAR_W-1:0] rx_char,
  input wire logic rx_char_valid,
  output logic rx_char_ready,
  output logic [CHAR_W-1:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  output logic dma_tx_req_n,
  output logic dma_rx_req_n,
  output logic rx_data_avail
);
  localparam int CW = $clog2(DEPTH + 1);

  // Control word fields.
  logic dma_mode_ff;
  logic fifo_en_ff;
  logic [1:0] rx_trig_ff;
  logic nxt_dma_mode;
  logic nxt_fifo_en;
  logic [1:0] nxt_rx_trig;

  // Register port decode.
  logic wr_sh_dma;
  logic wr_sh_en;
  logic wr_sh_trig;
  logic wr_fcw;
  logic wr_data;
  logic rd_data;

  // FIFO side signals.
  logic en_fall;
  logic rx_flush;
  logic tx_flush;
  logic rx_out_valid;
  logic [CHAR_W-1:0] rx_out_data;
  logic [CW-1:0] rx_count;
  logic rx_pop;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [CHAR_W-1:0] tx_out_data;
  logic [CW-1:0] tx_count;
  logic tx_pop;
  logic [CW-1:0] rx_level;
  logic rx_hit;

  // Registered outputs.
  logic [31:0] rdata_ff;
  logic [CHAR_W-1:0] tx_char_ff;
  logic tx_char_valid_ff;
  logic dma_tx_req_n_ff;
  logic dma_rx_req_n_ff;
  logic rx_data_avail_ff;

  assign wr_sh_dma = reg_wr && (reg_addr == UFSC_SH_DMA_MODE_ADDR);
  assign wr_sh_en = reg_wr && (reg_addr == UFSC_SH_FIFO_EN_ADDR);
  assign wr_sh_trig = reg_wr && (reg_addr == UFSC_SH_RX_TRIG_ADDR);
  assign wr_fcw = reg_wr && (reg_addr == UFSC_FCW_ADDR);
  assign wr_data = reg_wr && (reg_addr == UFSC_DATA_ADDR);
  assign rd_data = reg_rd && (reg_addr == UFSC_DATA_ADDR);

  // Each shadow write touches one field; the full word write touches all of them.
  always_comb begin
    nxt_dma_mode = dma_mode_ff;
    nxt_fifo_en = fifo_en_ff;
    nxt_rx_trig = rx_trig_ff;
    if (wr_sh_dma) begin
      nxt_dma_mode = reg_wdata[UFSC_SH_BIT];
    end
    if (wr_sh_en) begin
      nxt_fifo_en = reg_wdata[UFSC_SH_BIT];
    end
    if (wr_sh_trig) begin
      nxt_rx_trig = reg_wdata[UFSC_SH_TRIG_MSB:UFSC_SH_TRIG_LSB];
    end
    if (wr_fcw) begin
      nxt_dma_mode = reg_wdata[UFSC_FCW_DMA_BIT];
      nxt_fifo_en = reg_wdata[UFSC_FCW_EN_BIT];
      nxt_rx_trig = reg_wdata[UFSC_FCW_TRIG_MSB:UFSC_FCW_TRIG_LSB];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_mode_ff <= UFSC_RST_DMA_MODE;
      fifo_en_ff <= UFSC_RST_FIFO_EN;
      rx_trig_ff <= UFSC_RST_RX_TRIG;
    end else begin
      dma_mode_ff <= nxt_dma_mode;
      fifo_en_ff <= nxt_fifo_en;
      rx_trig_ff <= nxt_rx_trig;
    end
  end

  assign en_fall = fifo_en_ff & ~nxt_fifo_en;
  assign rx_flush = en_fall | (wr_fcw & reg_wdata[UFSC_FCW_RX_RST_BIT]);
  assign tx_flush = en_fall | (wr_fcw & reg_wdata[UFSC_FCW_TX_RST_BIT]);

  // A read of the data register pops only when a character is there.
  assign rx_pop = rd_data & rx_out_valid;

  // The holding stage takes a character whenever it is empty or being drained.
  assign tx_pop = tx_out_valid & (~tx_char_valid_ff | tx_char_ready);

  ufsc_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(DEPTH)
  ) u_receive_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .flush(rx_flush),
    .cap_one(~fifo_en_ff),
    .in_valid(rx_char_valid),
    .in_ready(rx_char_ready),
    .in_data(rx_char),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_out_data),
    .count(rx_count)
  );

  ufsc_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(DEPTH)
  ) u_transmit_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .flush(tx_flush),
    .cap_one(~fifo_en_ff),
    .in_valid(wr_data),
    .in_ready(tx_in_ready),
    .in_data(reg_wdata[CHAR_W-1:0]),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data),
    .count(tx_count)
  );

  // Decode of the receive trigger code into a fill level.
  always_comb begin
    rx_level = CW'(1);
    if (fifo_en_ff) begin
      unique case (rx_trig_ff)
        UFSC_TRIG_ONE: rx_level = CW'(1);
        UFSC_TRIG_QUARTER: rx_level = CW'(DEPTH / 4);
        UFSC_TRIG_HALF: rx_level = CW'(DEPTH / 2);
        UFSC_TRIG_TWO_SHORT: rx_level = CW'(DEPTH - 2);
      endcase
    end
  end

  assign rx_hit = (rx_count >= rx_level);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_data_avail_ff <= 1'b0;
    end else begin
      rx_data_avail_ff <= rx_hit;
    end
  end

  // Receive request: mode 0 follows any content, mode 1 waits for the trigger and
  // then holds until the FIFO runs dry, so a DMA burst is not cut short.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_rx_req_n_ff <= 1'b1;
    end else if (!dma_mode_ff) begin
      dma_rx_req_n_ff <= (rx_count == '0);
    end else if (rx_hit) begin
      dma_rx_req_n_ff <= 1'b0;
    end else if (rx_count == '0) begin
      dma_rx_req_n_ff <= 1'b1;
    end
  end

  // Transmit request: mode 0 only when empty, mode 1 from empty until full.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_tx_req_n_ff <= 1'b1;
    end else if (!dma_mode_ff) begin
      dma_tx_req_n_ff <= (tx_count != '0);
    end else if (tx_count == '0) begin
      dma_tx_req_n_ff <= 1'b0;
    end else if (!tx_in_ready) begin
      dma_tx_req_n_ff <= 1'b1;
    end
  end

  // Holding stage toward the serial transmitter; emptied by a transmit flush too.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_char_valid_ff <= 1'b0;
      tx_char_ff <= '0;
    end else if (tx_flush) begin
      tx_char_valid_ff <= 1'b0;
    end else if (tx_pop) begin
      tx_char_valid_ff <= 1'b1;
      tx_char_ff <= tx_out_data;
    end else if (tx_char_ready) begin
      tx_char_valid_ff <= 1'b0;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (!reg_rd) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      unique case (reg_addr)
        UFSC_SH_DMA_MODE_ADDR: rdata_ff[UFSC_SH_BIT] <= dma_mode_ff;
        UFSC_SH_FIFO_EN_ADDR: rdata_ff[UFSC_SH_BIT] <= fifo_en_ff;
        UFSC_SH_RX_TRIG_ADDR: rdata_ff[UFSC_SH_TRIG_MSB:UFSC_SH_TRIG_LSB] <= rx_trig_ff;
        UFSC_FCW_ADDR: begin
          rdata_ff[UFSC_FCW_EN_BIT] <= fifo_en_ff;
          rdata_ff[UFSC_FCW_DMA_BIT] <= dma_mode_ff;
          rdata_ff[UFSC_FCW_TRIG_MSB:UFSC_FCW_TRIG_LSB] <= rx_trig_ff;
        end
        UFSC_DATA_ADDR: begin
          if (rx_out_valid) begin
            rdata_ff[CHAR_W-1:0] <= rx_out_data;
          end
        end
        UFSC_STATUS_ADDR: begin
          rdata_ff[UFSC_ST_RX_NEMPTY_BIT] <= rx_out_valid;
          rdata_ff[UFSC_ST_TX_FULL_BIT] <= ~tx_in_ready;
          rdata_ff[UFSC_ST_RX_HIT_BIT] <= rx_hit;
          rdata_ff[UFSC_ST_FIFO_EN_BIT] <= fifo_en_ff;
          rdata_ff[UFSC_ST_RX_CNT_LSB +: CW] <= rx_count;
          rdata_ff[UFSC_ST_TX_CNT_LSB +: CW] <= tx_count;
        end
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign tx_char = tx_char_ff;
  assign tx_char_valid = tx_char_valid_ff;
  assign dma_tx_req_n = dma_tx_req_n_ff;
  assign dma_rx_req_n = dma_rx_req_n_ff;
  assign rx_data_avail = rx_data_avail_ff;

endmodule

/* File: ufsc_chk.sv */
// Checker of control word readback and flush behaviour at the top ports.
module ufsc_chk
  import ufsc_pkg::*;
#(
  parameter int CHAR_W = UFSC_CHAR_W,
  parameter int DEPTH = UFSC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [CHAR_W-1:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic rx_char_ready,
  input wire logic [CHAR_W-1:0] tx_char,
  input wire logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic dma_tx_req_n,
  input wire logic dma_rx_req_n,
  input wire logic rx_data_avail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_ff;
  logic dma_ff;
  logic [1:0] trig_ff;
  logic rd_fcw;
  logic wr_fcw;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  assign rd_fcw = reg_rd && reg_addr == UFSC_FCW_ADDR;
  assign wr_fcw = reg_wr && reg_addr == UFSC_FCW_ADDR;
  // Own copy of the fields, so readback is judged without the design's state.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) en_ff <= 1'h0;
    else if (wr_fcw || (reg_wr && reg_addr == UFSC_SH_FIFO_EN_ADDR)) en_ff <= reg_wdata[0];
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) dma_ff <= 1'h0;
    else if (wr_fcw) dma_ff <= reg_wdata[3];
    else if (reg_wr && reg_addr == UFSC_SH_DMA_MODE_ADDR) dma_ff <= reg_wdata[0];
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) trig_ff <= 2'h0;
    else if (wr_fcw) trig_ff <= reg_wdata[7:6];
    else if (reg_wr && reg_addr == UFSC_SH_RX_TRIG_ADDR) trig_ff <= reg_wdata[1:0];
  end
  property p_fcw_dma; rd_fcw |=> reg_rdata[3] == dma_ff; endproperty
  a_fcw_dma: assert property (p_fcw_dma)
    else $error("control word mode bit wrong");
  property p_fcw_en; rd_fcw |=> reg_rdata[0] == en_ff; endproperty
  a_fcw_en: assert property (p_fcw_en)
    else $error("control word enable bit wrong");
  property p_fcw_trig; rd_fcw |=> reg_rdata[7:6] == trig_ff; endproperty
  a_fcw_trig: assert property (p_fcw_trig)
    else $error("control word trigger field wrong");
  property p_fcw_rest;
    rd_fcw |=> reg_rdata[31:8] == 24'h0 && reg_rdata[5:4] == 2'h0 && reg_rdata[2:1] == 2'h0;
  endproperty
  a_fcw_rest: assert property (p_fcw_rest)
    else $error("control word other bits not zero");
  property p_sh_dma;
    reg_rd && reg_addr == UFSC_SH_DMA_MODE_ADDR |=> reg_rdata == {31'h0, dma_ff};
  endproperty
  a_sh_dma: assert property (p_sh_dma)
    else $error("mode shadow readback wrong");
  property p_sh_en;
    reg_rd && reg_addr == UFSC_SH_FIFO_EN_ADDR |=> reg_rdata == {31'h0, en_ff};
  endproperty
  a_sh_en: assert property (p_sh_en)
    else $error("enable shadow readback wrong");
  property p_sh_trig;
    reg_rd && reg_addr == UFSC_SH_RX_TRIG_ADDR |=> reg_rdata == {30'h0, trig_ff};
  endproperty
  a_sh_trig: assert property (p_sh_trig)
    else $error("trigger shadow readback wrong");
  property p_flush;
    reg_wr && reg_addr == UFSC_SH_FIFO_EN_ADDR && !reg_wdata[0] && en_ff
      |=> rx_char_ready && !tx_char_valid;
  endproperty
  a_flush: assert property (p_flush)
    else $error("fifos not emptied when enable cleared");
endmodule

/* File: ufsc_partner.sv */
// Transmit sink standing for the far end; it records every character it takes.
module ufsc_partner
  import ufsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic [UFSC_CHAR_W-1:0] tx_char,
  input wire logic tx_char_valid,
  output logic tx_char_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [UFSC_CHAR_W-1:0] got[$];
  // Ready alternates so the sender must hold its character across slow cycles.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_char_ready <= 1'h0;
    end else begin
      if (tx_char_valid && tx_char_ready) got.push_back(tx_char);
      tx_char_ready <= !stall && !tx_char_ready;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the FIFO shadow controls.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ufsc_pkg::*;
  logic sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, stall = 1'h1;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rd;
  logic [7:0] rx_char = 8'h0, tx_char;
  logic rx_char_valid = 1'h0, rx_char_ready, tx_char_valid, tx_char_ready;
  logic dma_tx_req_n, dma_rx_req_n, rx_data_avail;
  int miscompares = 0, total_checks = 0, cycles = 0, seed = 87;
  logic [7:0] q[$], tq[$];
  logic en = 1'h0, dma = 1'h0;
  logic [1:0] trig = 2'h0;
  int lv[4] = '{1, UFSC_FIFO_DEPTH / 4, UFSC_FIFO_DEPTH / 2, UFSC_FIFO_DEPTH - 2};
  logic [31:0] ra[5] = '{UFSC_SH_DMA_MODE_ADDR, UFSC_SH_FIFO_EN_ADDR, UFSC_SH_RX_TRIG_ADDR,
    UFSC_FCW_ADDR, 32'h5000_10d0};

  ufsc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_char_ready(rx_char_ready),
    .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
    .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n), .rx_data_avail(rx_data_avail));
  ufsc_partner u_part (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
    .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready));

  always #10 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    if (a == UFSC_SH_FIFO_EN_ADDR) en = d[0];
    if (a == UFSC_SH_DMA_MODE_ADDR) dma = d[0];
    if (a == UFSC_SH_RX_TRIG_ADDR) trig = d[1:0];
    // The full word sets all three fields at once; its flush bits never read back.
    if (a == UFSC_FCW_ADDR) begin
      en = d[0];
      dma = d[3];
      trig = d[7:6];
    end
  endtask
  task automatic rd_reg(input logic [31:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    rd = reg_rdata;
  endtask
  task automatic push(input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    rx_char_valid <= 1'h1;
    rx_char <= d;
    @(negedge sys_clk);
    while (rx_char_ready !== 1'h1 && n < 50) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    rx_char_valid <= 1'h0;
    rx_char <= ~d;
    q.push_back(d);
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic check_rx(input int lvl, input bit reached);
    int n = q.size();
    chk1(rx_data_avail, n >= lvl);
    chk1(dma_rx_req_n, !(dma ? (n >= lvl || (reached && n != 0)) : n != 0));
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk32(rd, 32'h0);
    end
    // Random shadow writes must each move only their own field of the word.
    repeat (8) begin
      wr(ra[$unsigned($random(seed)) % 3], $random(seed));
      rd_reg(UFSC_FCW_ADDR);
      chk32(rd, {24'h0, trig, 2'h0, dma, 2'h0, en});
    end
    wr(UFSC_SH_FIFO_EN_ADDR, 32'h1);
    for (int m = 0; m < 2; m++) begin
      for (int t = 0; t < 4; t++) begin
        wr(UFSC_SH_DMA_MODE_ADDR, m);
        wr(UFSC_SH_RX_TRIG_ADDR, t);
        settle();
        check_rx(lv[t], 0);
        repeat (lv[t]) begin
          push($random(seed));
          settle();
          check_rx(lv[t], 0);
        end
        while (q.size() > 0) begin
          rd_reg(UFSC_DATA_ADDR);
          chk32(rd, {24'h0, q.pop_front()});
          settle();
          check_rx(lv[t], 1);
        end
      end
    end
    wr(UFSC_SH_DMA_MODE_ADDR, 32'h0);
    settle();
    chk1(dma_tx_req_n, 1'h0);
    repeat (3) begin
      rd = $random(seed);
      tq.push_back(rd[7:0]);
      wr(UFSC_DATA_ADDR, rd);
    end
    settle();
    chk1(dma_tx_req_n, 1'h1);
    @(posedge sys_clk);
    stall <= 1'h0;
    for (int i = 0; i < 200 && u_part.got.size() < 3; i++) @(posedge sys_clk);
    foreach (tq[i]) chk32({24'h0, u_part.got[i]}, {24'h0, tq[i]});
    stall <= 1'h1;
    // Scheme one keeps the transmit request low from empty until the FIFO is full.
    wr(UFSC_SH_DMA_MODE_ADDR, 32'h1);
    settle();
    chk1(dma_tx_req_n, 1'h0);
    wr(UFSC_DATA_ADDR, 32'h5a);
    wr(UFSC_DATA_ADDR, 32'ha5);
    settle();
    chk1(dma_tx_req_n, 1'h0);
    repeat (UFSC_FIFO_DEPTH - 1) wr(UFSC_DATA_ADDR, $random(seed));
    settle();
    chk1(dma_tx_req_n, 1'h1);
    repeat (UFSC_FIFO_DEPTH) push($random(seed));
    settle();
    chk1(rx_char_ready, 1'h0);
    wr(UFSC_SH_FIFO_EN_ADDR, 32'h0);
    q.delete();
    settle();
    rd_reg(UFSC_STATUS_ADDR);
    chk32(rd, 32'h0);
    chk1(rx_data_avail, 1'h0);
    chk32(32'(u_part.got.size()), 32'h0000_0003);
    // The full word enables again, then a second full write flushes only the receiver.
    wr(UFSC_FCW_ADDR, 32'h0000_00c9);
    push(8'h3c);
    wr(UFSC_FCW_ADDR, 32'h0000_00cb);
    q.delete();
    settle();
    rd_reg(UFSC_FCW_ADDR);
    chk32(rd, {24'h0, trig, 2'h0, dma, 2'h0, en});
    rd_reg(UFSC_STATUS_ADDR);
    chk32(rd, 32'h0000_0008);
    give_verdict();
  end
endmodule

bind ufsc_top ufsc_chk #(.CHAR_W(CHAR_W), .DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char(rx_char), .rx_char_valid(rx_char_valid),
  .rx_char_ready(rx_char_ready), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
  .tx_char_ready(tx_char_ready), .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n),
  .rx_data_avail(rx_data_avail));
